// >>> fsbd_pkg.sv
// Package of constants and carrier types for the flash bus controller.
// Functional notes
// - Read: chip select and output strobe low.
// - Write: write strobe and chip select low.
// - Only listed pin combinations are ever driven.
// - Bypass program takes two writes, not four.
// - Under accelerate, issue only bypass programs.
package fsbd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL  = 12'h000;
  localparam logic [11:0] REG_ADDR  = 12'h004;
  localparam logic [11:0] REG_WDATA = 12'h008;
  localparam logic [11:0] REG_RDATA = 12'h00C;
  localparam logic [11:0] REG_STAT  = 12'h010;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_WORD_BIT  = 2;
  localparam int CTRL_PROT_BIT  = 3;
  localparam int CTRL_ACCEL_BIT = 4;
  localparam int CTRL_RST_BIT   = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0024;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_ACC_NS      = 70;
  localparam int T_WP_NS       = 35;
  localparam int T_SETUP_NS    = 25;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SU_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        word;
    logic [19:0] addr;
  } fsbd_ctl_t;

  typedef struct packed {
    logic [15:0] dq_o;
    logic [15:0] dq_oe;
  } fsbd_dq_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_RDACC = 5'b00100,
    ST_WRPUL = 5'b01000,
    ST_HOLD  = 5'b10000
  } fsbd_state_t;

endpackage

// >>> fsbd_ctrl.sv
// Host controller that runs flash read and command-write cycles.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module fsbd_ctrl
  import fsbd_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input  wire logic              CLOCK_I,
  input  wire logic              ARST_N_I,
  input  wire logic [11:0]       PADDR_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  output logic                   CE_F_N_O,
  output logic                   CE_S_N_O,
  output logic                   OE_N_O,
  output logic                   WE_N_O,
  output logic                   BYTE_N_WORD_O,
  output logic                   RESET_N_O,
  output logic                   PROTECT_ACCEL_O,
  output logic                   ACCEL_HV_O,
  output logic      [ADDR_W-1:0] ADDR_O,
  output logic      [15:0]       DQ_O,
  output logic      [15:0]       DQ_OE_O,
  input  wire logic [15:0]       DQ_I,
  input  wire logic              READY_BUSY_IN_I
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Reset is applied at once and released on the clock after two flops.
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [16:0] sync1_q;
  logic [16:0] sync2_q;
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 17'h00000;
      sync2_q <= 17'h00000;
    end else begin
      sync1_q <= {READY_BUSY_IN_I, DQ_I};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0]       ctrl_q;
  logic [ADDR_W:0]   addr_q;
  logic [15:0]       wdata_q;
  logic [15:0]       rdata_q;
  logic              busy_q;
  logic              done_q;
  fsbd_state_t       state_q;
  logic [7:0]        cnt_q;
  fsbd_ctl_t         pins_q;
  fsbd_dq_t          dq_q;

  logic wr_acc;
  logic rd_acc;
  logic start;
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_acc = PSEL_I && PENABLE_I && !PWRITE_I;
  assign start  = wr_acc && (PADDR_I == REG_CTRL) && PWDATA_I[CTRL_GO_BIT] && !busy_q;

  // Every register answers in its access cycle, so there are no wait states.
  assign PREADY_O  = 1'b1;

  // One-hot register select, shared by the error path and the status clear.
  function automatic logic [4:0] reg_sel(input logic [11:0] a);
    if (a == REG_CTRL) begin
      reg_sel = 5'b00001;
    end else if (a == REG_ADDR) begin
      reg_sel = 5'b00010;
    end else if (a == REG_WDATA) begin
      reg_sel = 5'b00100;
    end else if (a == REG_RDATA) begin
      reg_sel = 5'b01000;
    end else if (a == REG_STAT) begin
      reg_sel = 5'b10000;
    end else begin
      reg_sel = 5'b00000;
    end
  endfunction

  logic [4:0] sel;
  assign sel = reg_sel(PADDR_I);

  assign PSLVERR_O = PSEL_I && PENABLE_I && (sel == 5'b00000);

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= CTRL_RESET;
      addr_q  <= '0;
      wdata_q <= 16'h0000;
    end else if (wr_acc) begin
      if (PADDR_I == REG_CTRL) begin
        ctrl_q <= PWDATA_I & 32'h0000_003E;
      end else if (PADDR_I == REG_ADDR) begin
        addr_q <= PWDATA_I[ADDR_W:0];
      end else if (PADDR_I == REG_WDATA) begin
        wdata_q <= PWDATA_I[15:0];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      if (PADDR_I == REG_CTRL) begin
        PRDATA_O <= ctrl_q;
      end else if (PADDR_I == REG_ADDR) begin
        PRDATA_O <= 32'(addr_q);
      end else if (PADDR_I == REG_WDATA) begin
        PRDATA_O <= {16'h0000, wdata_q};
      end else if (PADDR_I == REG_RDATA) begin
        PRDATA_O <= {16'h0000, rdata_q};
      end else if (PADDR_I == REG_STAT) begin
        PRDATA_O <= {29'h0000_0000, sync2_q[16], done_q, busy_q};
      end else begin
        PRDATA_O <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  logic is_write;
  logic is_word;
  logic op_write_q;
  logic op_word_q;

  // Direction and width are frozen when a cycle starts, so a control
  // write during a cycle cannot switch strobes or lanes half way.
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      op_write_q <= 1'b0;
      op_word_q  <= 1'b1;
    end else if (start) begin
      op_write_q <= PWDATA_I[CTRL_WRITE_BIT];
      op_word_q  <= PWDATA_I[CTRL_WORD_BIT];
    end
  end

  assign is_write = op_write_q;
  assign is_word  = op_word_q;

  // Lanes the controller drives: lane fifteen carries the low address
  // bit in byte mode, and a write adds the data lanes of its width.
  function automatic logic [15:0] lane_oe(input logic word, input logic write);
    if (word) begin
      lane_oe = write ? 16'hFFFF : 16'h0000;
    end else begin
      lane_oe = write ? 16'h80FF : 16'h8000;
    end
  endfunction

  // Values the controller puts on the lanes it drives.
  function automatic logic [15:0] lane_data(input logic word, input logic a0,
                                            input logic [15:0] d);
    lane_data = word ? d : {a0, 7'h00, d[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
    end else if (state_q == ST_HOLD) begin
      busy_q <= 1'b0;
    end
  end

  // Done is sticky; a finishing cycle wins over a clear in the same clock.
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (state_q == ST_HOLD) begin
      done_q <= 1'b1;
    end else if (start || (wr_acc && sel[4])) begin
      done_q <= 1'b0;
    end
  end

  // Read data is taken once, at the last count of the access time, which
  // covers the two input flops.
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if ((state_q == ST_RDACC) && (cnt_q <= 8'h01)) begin
      rdata_q <= is_word ? sync2_q[15:0] : {8'h00, sync2_q[7:0]};
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= 8'h00;
      pins_q  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, word: 1'b1, addr: 20'h00000};
      dq_q    <= '{dq_o: 16'h0000, dq_oe: 16'h0000};
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q     <= ST_SETUP;
            cnt_q       <= 8'(SU_CYC);
            pins_q.word <= PWDATA_I[CTRL_WORD_BIT];
            // Byte mode uses the low address bit on lane fifteen.
            pins_q.addr <= PWDATA_I[CTRL_WORD_BIT] ? addr_q[19:0] : addr_q[20:1];
            pins_q.ce_n <= 1'b0;
          end
        end
        ST_SETUP: begin
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (is_write) begin
            // Command write: strobe low, output strobe held high.
            pins_q.we_n <= 1'b0;
            dq_q.dq_o   <= lane_data(is_word, addr_q[0], wdata_q);
            dq_q.dq_oe  <= lane_oe(is_word, 1'b1);
            cnt_q       <= 8'(WP_CYC);
            state_q     <= ST_WRPUL;
          end else begin
            // Array read: output strobe low, write strobe held high.
            pins_q.oe_n <= 1'b0;
            dq_q.dq_o   <= lane_data(is_word, addr_q[0], 16'h0000);
            dq_q.dq_oe  <= lane_oe(is_word, 1'b0);
            cnt_q       <= 8'(ACC_CYC);
            state_q     <= ST_RDACC;
          end
        end
        ST_RDACC: begin
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            pins_q.oe_n <= 1'b1;
            state_q     <= ST_HOLD;
          end
        end
        ST_WRPUL: begin
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            // Data is latched by the device on this rising strobe edge.
            pins_q.we_n <= 1'b1;
            state_q     <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          pins_q.ce_n <= 1'b1;
          dq_q.dq_oe  <= 16'h0000;
          state_q     <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Static RAM stays deselected so the two chips never share the bus.
  assign CE_F_N_O        = pins_q.ce_n;
  assign CE_S_N_O        = 1'b1;
  assign OE_N_O          = pins_q.oe_n;
  assign WE_N_O          = pins_q.we_n;
  assign BYTE_N_WORD_O   = pins_q.word;
  assign ADDR_O          = ADDR_W'(pins_q.addr);
  assign DQ_O            = dq_q.dq_o;
  assign DQ_OE_O         = dq_q.dq_oe;
  assign RESET_N_O       = ~ctrl_q[CTRL_RST_BIT] ? 1'b0 : 1'b1;
  assign PROTECT_ACCEL_O = ~ctrl_q[CTRL_PROT_BIT];
  assign ACCEL_HV_O      = ctrl_q[CTRL_ACCEL_BIT];

endmodule
`default_nettype wire

// >>> fsbd_ctrl_assertions.sv
// Checker of the flash pin protocol at the controller ports.
`timescale 1ns/1ps
`default_nettype none
module fsbd_ctrl_chk (
  input wire logic        CLOCK_I,
  input wire logic        ARST_N_I,
  input wire logic        CE_F_N_O,
  input wire logic        CE_S_N_O,
  input wire logic        OE_N_O,
  input wire logic        WE_N_O,
  input wire logic        BYTE_N_WORD_O,
  input wire logic [15:0] DQ_O,
  input wire logic [15:0] DQ_OE_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_pulse;
    !WE_N_O [*2] ##1 WE_N_O;
  endsequence
  property p_rd; !OE_N_O |-> !CE_F_N_O && WE_N_O; endproperty
  property p_wr; !WE_N_O |-> !CE_F_N_O && OE_N_O; endproperty
  property p_inh; CE_S_N_O && (OE_N_O || WE_N_O); endproperty
  property p_bus; DQ_OE_O[14:0] != 15'h0000 |-> OE_N_O; endproperty
  property p_word; BYTE_N_WORD_O && !WE_N_O |-> DQ_OE_O == 16'hFFFF; endproperty
  property p_byte; !BYTE_N_WORD_O |-> DQ_OE_O[14:8] == 7'h00; endproperty
  property p_hold; !WE_N_O && $past(!WE_N_O) |-> $stable(DQ_O); endproperty
  property p_wp; $fell(WE_N_O) |-> s_pulse; endproperty
  a_rd: assert property (p_rd) else $error("read strobe bad");
  a_wr: assert property (p_wr) else $error("write strobe bad");
  a_inh: assert property (p_inh) else $error("inhibited pins");
  a_bus: assert property (p_bus) else $error("data clash");
  a_word: assert property (p_word) else $error("word lanes");
  a_byte: assert property (p_byte) else $error("byte lanes");
  a_hold: assert property (p_hold) else $error("data moved");
  a_wp: assert property (p_wp) else $error("write pulse");
endmodule
bind fsbd_ctrl fsbd_ctrl_chk i_chk (
  .CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .CE_F_N_O(CE_F_N_O), .CE_S_N_O(CE_S_N_O),
  .OE_N_O(OE_N_O), .WE_N_O(WE_N_O), .BYTE_N_WORD_O(BYTE_N_WORD_O), .DQ_O(DQ_O),
  .DQ_OE_O(DQ_OE_O)
);
`default_nettype wire

// >>> fsbd_flash_model.sv
// Behavioural flash device facing the controller pins.
`timescale 1ns/1ps
`default_nettype none
module fsbd_flash_model
  import fsbd_pkg::*;
(
  input  wire fsbd_ctl_t   ctl_i,
  input  wire logic [15:0] dq_i,
  output fsbd_dq_t         dq_o,
  output logic             rb_o
);
  logic [15:0] mem [256];
  logic [15:0] wd;
  logic [7:0]  wa;
  logic [7:0]  a;
  logic        pend;
  assign a = ctl_i.addr[7:0];
  initial begin
    pend = 1'b0;
    rb_o = 1'b1;
    for (int i = 0; i < 256; i++) mem[i] = {8'(i), ~8'(i)};
  end
  always_comb begin
    dq_o = '0;
    if (!ctl_i.ce_n && !ctl_i.oe_n && ctl_i.we_n) begin
      dq_o.dq_oe = ctl_i.word ? 16'hFFFF : 16'h00FF;
      dq_o.dq_o  = ctl_i.word ? mem[a] : {8'h00, dq_i[15] ? mem[a][15:8] : mem[a][7:0]};
    end
  end
  always @(negedge ctl_i.we_n) wa = a;
  always @(posedge ctl_i.we_n) begin
    wd = dq_i;
    if (!ctl_i.ce_n && pend) begin
      pend <= 1'b0;
      rb_o <= 1'b0;
      rb_o <= #300 1'b1;
      if (ctl_i.word) mem[wa] <= wd;
      else if (wd[15]) mem[wa][15:8] <= wd[7:0];
      else mem[wa][7:0] <= wd[7:0];
    end else if (!ctl_i.ce_n) begin
      pend <= (wd[7:0] == 8'hA0);
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the flash bus controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fsbd_pkg::*;
;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, cx;
  logic        pready, pslverr, ce_n, ces_n, oe_n, we_n, wrd, rst_n, prot, hv, rb;
  logic [19:0] addr;
  logic [15:0] dqd, dqe, dq;
  fsbd_ctl_t   fc;
  fsbd_dq_t    fd;
  int          error_cnt = 0;
  int          check_count = 0;
  always #12.5 clk = ~clk;
  assign fc = {ce_n, oe_n, we_n, wrd, addr};
  assign dq = (dqe & dqd) | (fd.dq_oe & fd.dq_o) | (~(dqe | fd.dq_oe) & ~dqd);
  fsbd_ctrl i_dut (.CLOCK_I(clk), .ARST_N_I(arst_n), .PADDR_I(paddr), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .CE_F_N_O(ce_n), .CE_S_N_O(ces_n),
    .OE_N_O(oe_n), .WE_N_O(we_n), .BYTE_N_WORD_O(wrd), .RESET_N_O(rst_n),
    .PROTECT_ACCEL_O(prot), .ACCEL_HV_O(hv), .ADDR_O(addr), .DQ_O(dqd), .DQ_OE_O(dqe),
    .DQ_I(dq), .READY_BUSY_IN_I(rb));
  fsbd_flash_model i_mem (.ctl_i(fc), .dq_i(dq), .dq_o(fd), .rb_o(rb));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      error_cnt++;
      $display("MISMATCH at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    if (n >= 20) give_verdict();
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fop(input logic wr, input logic wd, input logic [31:0] a,
                     input logic [31:0] d, input logic [31:0] x);
    logic [31:0] s;
    logic        e;
    int          n;
    apb(1'b1, REG_ADDR, a, s, e);
    apb(1'b1, REG_WDATA, d, s, e);
    apb(1'b1, REG_CTRL, cx | 32'h21 | {29'h0, wd, wr, 1'b0}, s, e);
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0, s, e);
      n++;
    end while (s[1] !== 1'b1 && n < 40);
    if (n >= 40) error_cnt++;
    if (n >= 40) give_verdict();
    apb(1'b0, REG_RDATA, 32'h0, s, e);
    if (!wr) chk(s, x);
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    apb(1'b0, REG_CTRL, 32'h0, r, e);
    chk(r, CTRL_RESET);
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic t_read;
    fop(1'b0, 1'b1, 32'h3, 32'h0, 32'h03FC);
    fop(1'b0, 1'b0, 32'h7, 32'h0, 32'h0003);
    fop(1'b0, 1'b0, 32'h6, 32'h0, 32'h00FC);
  endtask
  task automatic t_prog;
    cx = 32'h10;
    fop(1'b1, 1'b1, 32'h5, 32'hA0, 32'h0);
    fop(1'b1, 1'b1, 32'h5, 32'h1234, 32'h0);
    cx = 32'h0;
    fop(1'b0, 1'b1, 32'h5, 32'h0, 32'h1234);
    fop(1'b1, 1'b0, 32'hC, 32'hA0, 32'h0);
    fop(1'b1, 1'b0, 32'hC, 32'h5A, 32'h0);
    fop(1'b0, 1'b1, 32'h6, 32'h0, 32'h065A);
    fop(1'b1, 1'b1, 32'h8, 32'hF0, 32'h0);
    fop(1'b0, 1'b1, 32'h8, 32'h0, 32'h08F7);
  endtask
  task automatic t_pins;
    logic [31:0] r;
    logic        e;
    apb(1'b1, REG_CTRL, 32'h28, r, e);
    @(negedge clk);
    chk({30'h0, prot, hv}, 32'h0);
    apb(1'b1, REG_CTRL, 32'h30, r, e);
    @(negedge clk);
    chk({29'h0, rst_n, prot, hv}, 32'h7);
    apb(1'b1, REG_CTRL, 32'h00, r, e);
    @(negedge clk);
    chk({29'h0, rst_n, prot, hv}, 32'h2);
  endtask
  initial begin
    cx = 32'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_read();
    t_prog();
    t_pins();
    give_verdict();
  end
  initial begin
    #100us;
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
